// ==== meter_regs_pkg.sv ====
// constants, register map and carrier types of the meter result registers
package meter_regs_pkg;

    // ------------------------------------------------------------------
    // clock and register map (word index, byte address is index times 4)
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam logic [7:0] IDX_PULSE_FREQ = 8'h06;
    localparam logic [7:0] IDX_INST_CURRENT = 8'h07;
    localparam logic [7:0] IDX_INST_VOLTAGE = 8'h08;
    localparam logic [7:0] IDX_INST_POWER = 8'h09;
    localparam logic [7:0] IDX_MEAN_POWER = 8'h0A;
    localparam logic [7:0] IDX_RMS_CURRENT = 8'h0B;
    localparam logic [7:0] IDX_RMS_VOLTAGE = 8'h0C;
    localparam logic [7:0] IDX_POWER_BIAS = 8'h0E;
    localparam logic [7:0] IDX_EVENT_FLAGS = 8'h0F;
    localparam logic [7:0] IDX_EVENT_MASK = 8'h1A;
    localparam logic [7:0] IDX_IRQ_CONFIG = 8'h1C;
    localparam logic [7:0] IDX_CYCLE_LEN = 8'h1D;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [23:0] PULSE_FREQ_RESET = 24'h0FA000;
    localparam logic [23:0] POWER_BIAS_RESET = 24'h000000;
    localparam logic [23:0] FLAGS_RESET = 24'h000001;
    localparam logic [23:0] MASK_RESET = 24'h000000;
    localparam logic [23:0] CYCLE_LEN_RESET = 24'h000FA0;
    localparam logic [1:0] IRQ_CONFIG_RESET = 2'h0;
    localparam logic [23:0] FLAGS_IMPL = 24'h9370DF;
    localparam int BIT_CYCLE_COMPLETE = 23;
    localparam int BIT_SAMPLE_READY = 20;
    localparam int BIT_CURRENT_OVF = 17;
    localparam int BIT_VOLTAGE_OVF = 16;
    localparam int BIT_CURRENT_MS_OVF = 14;
    localparam int BIT_VOLTAGE_MS_OVF = 13;
    localparam int BIT_ENERGY_OVF = 12;
    localparam int BIT_TEMP_UPDATED = 7;
    localparam int BIT_TEMP_OSC = 6;
    localparam int BIT_VOLTAGE_OSC = 4;
    localparam int BIT_CURRENT_OSC = 3;
    localparam int BIT_LOW_SUPPLY = 2;
    localparam int BIT_SAG = 1;
    localparam int BIT_CMD_VALID = 0;
    localparam int BIT_IRQ_POLARITY = 0;
    localparam int BIT_IRQ_STYLE = 1;

    // ------------------------------------------------------------------
    // pulse generator and interrupt timing
    // ------------------------------------------------------------------
    localparam int PULSE_FRAC_BITS = 5;
    localparam logic [29:0] PULSE_ACC_LIMIT = 30'(CLK_HZ * (1 << PULSE_FRAC_BITS));
    localparam logic [29:0] PULSE_RATE_MAX = 30'(CLK_HZ * (1 << PULSE_FRAC_BITS) / 8);
    localparam logic [29:0] PULSE_RATE_MIN = 30'h00000002;
    localparam logic [2:0] IRQ_PULSE_CYCLES = 3'h4;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CALC_IDLE, CALC_DIV_POWER, CALC_DIV_ISQ, CALC_ROOT_I,
        CALC_DIV_VSQ, CALC_ROOT_V
    } calc_e;

    typedef struct packed {
        logic valid;
        logic [23:0] current;
        logic [23:0] voltage;
        logic current_over;
        logic voltage_over;
    } sample_in_s;

    typedef struct packed {
        logic calibration_done;
        logic temperature_updated;
        logic temperature_osc;
        logic voltage_osc;
        logic current_osc;
        logic sag_detected;
        logic invalid_command;
        logic status_read_failed;
    } event_in_s;

    typedef struct packed {
        logic below_low;
        logic above_high;
    } supply_pins_s;

endpackage

// ==== meter_result_and_event_registers.sv ====
// result, pulse-rate and event-flag register bank on an ahb-lite slave
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module meter_result_and_event_registers (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // measurement front end and event sources
    input wire meter_regs_pkg::sample_in_s sample_in,
    input wire meter_regs_pkg::event_in_s event_in,
    input wire meter_regs_pkg::supply_pins_s supply_pins,
    // output pins
    output logic energy_pulse_out_a_n,
    output logic energy_pulse_out_b_n,
    output logic irq_out
);
    import meter_regs_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr_pending;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic [23:0] pulse_freq;
        logic [23:0] power_bias;
        logic [23:0] flags;
        logic [23:0] mask;
        logic [23:0] cycle_len;
        logic [1:0] irq_cfg;
        logic [23:0] inst_current;
        logic [23:0] inst_voltage;
        logic [23:0] inst_power;
        logic [23:0] mean_power;
        logic [23:0] rms_current;
        logic [23:0] rms_voltage;
        logic [23:0] conv_count;
        logic [48:0] acc_power;
        logic [48:0] acc_isq;
        logic [48:0] acc_vsq;
        logic [48:0] lat_isq;
        logic [48:0] lat_vsq;
        calc_e calc;
        logic [5:0] step;
        logic [48:0] div_quo;
        logic [24:0] div_rem;
        logic neg;
        logic [47:0] radicand;
        logic [23:0] root;
        logic [25:0] root_rem;
        logic root_ovf;
        logic [29:0] pulse_acc;
        logic pulse_a_n;
        logic pulse_b_n;
        logic [1:0] sup_meta;
        logic [1:0] sup_sync;
        logic req_d;
        logic [2:0] irq_cnt;
        logic irq_pin;
    } state_s;

    state_s st;
    state_s next_st;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // squared sample scaled so that full scale is 2^24
    function automatic logic [24:0] square_scaled(input logic [23:0] s);
        logic signed [47:0] sq;
        sq = $signed(s) * $signed(s);
        return sq[46:22];
    endfunction

    // one restoring division step, returns {remainder, quotient}
    function automatic logic [73:0] div_step(input logic [48:0] quo,
            input logic [24:0] rem, input logic [23:0] divisor);
        logic [24:0] shifted;
        logic [48:0] q;
        shifted = {rem[23:0], quo[48]};
        q = {quo[47:0], 1'b0};
        if (shifted >= {1'b0, divisor}) begin
            shifted = shifted - {1'b0, divisor};
            q[0] = 1'b1;
        end
        return {shifted, q};
    endfunction

    // one bit of the square root, returns {remainder, root}
    function automatic logic [49:0] root_step(input logic [25:0] rem,
            input logic [23:0] root, input logic [1:0] pair);
        logic [25:0] r;
        logic [25:0] trial;
        logic [23:0] q;
        r = {rem[23:0], pair};
        trial = {root, 2'b01};
        q = {root[22:0], 1'b0};
        if (r >= trial) begin
            r = r - trial;
            q[0] = 1'b1;
        end
        return {r, q};
    endfunction

    function automatic logic [23:0] cycle_length(input logic [23:0] n);
        return (n == 24'h000000) ? 24'h000001 : n;
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        case (idx)
            IDX_PULSE_FREQ, IDX_INST_CURRENT, IDX_INST_VOLTAGE,
            IDX_INST_POWER, IDX_MEAN_POWER, IDX_RMS_CURRENT,
            IDX_RMS_VOLTAGE, IDX_POWER_BIAS, IDX_EVENT_FLAGS,
            IDX_EVENT_MASK, IDX_IRQ_CONFIG, IDX_CYCLE_LEN: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic addr_ok;
        logic [7:0] idx;
        logic [23:0] rd;
        logic [23:0] set_vec;
        logic [23:0] clr_vec;
        logic [73:0] dq;
        logic [49:0] rq;
        logic [48:0] quo;
        logic signed [47:0] prod;
        logic [23:0] pw;
        logic [48:0] acc_p;
        logic [48:0] acc_i;
        logic [48:0] acc_v;
        logic [29:0] rate;
        logic [29:0] psum;
        logic fire;
        logic req;
        addr_ok = 1'b0;
        idx = 8'h00;
        rd = 24'h000000;
        set_vec = 24'h000000;
        clr_vec = 24'h000000;
        dq = '0;
        rq = '0;
        quo = '0;
        prod = '0;
        pw = 24'h000000;
        acc_p = '0;
        acc_i = '0;
        acc_v = '0;
        rate = '0;
        psum = '0;
        fire = 1'b0;
        req = 1'b0;
        next_st = st;

        // supply comparator pins cross into the clock domain
        next_st.sup_meta = {supply_pins.below_low, supply_pins.above_high};
        next_st.sup_sync = st.sup_meta;

        // bus address phase: reads are answered from a flop next cycle
        addr_ok = hsel && htrans[1] && hready && (haddr[31:10] == 22'h0)
            && (haddr[1:0] == 2'b00);
        idx = haddr[9:2];
        case (idx)
            IDX_PULSE_FREQ: rd = st.pulse_freq;
            IDX_INST_CURRENT: rd = st.inst_current;
            IDX_INST_VOLTAGE: rd = st.inst_voltage;
            IDX_INST_POWER: rd = st.inst_power;
            IDX_MEAN_POWER: rd = st.mean_power;
            IDX_RMS_CURRENT: rd = st.rms_current;
            IDX_RMS_VOLTAGE: rd = st.rms_voltage;
            IDX_POWER_BIAS: rd = st.power_bias;
            IDX_EVENT_FLAGS: rd = st.flags & FLAGS_IMPL;
            IDX_EVENT_MASK: rd = st.mask & FLAGS_IMPL;
            IDX_IRQ_CONFIG: rd = {22'h000000, st.irq_cfg};
            IDX_CYCLE_LEN: rd = st.cycle_len;
            default: rd = 24'h000000;
        endcase
        if (hsel && htrans[1] && hready && !hwrite) begin
            next_st.rdata = addr_ok ? {8'h00, rd} : 32'h00000000;
        end
        next_st.wr_pending = addr_ok && hwrite && (hsize == HSIZE_WORD)
            && is_mapped(idx);
        next_st.wr_idx = idx;

        // bus data phase of a write
        if (st.wr_pending) begin
            case (st.wr_idx)
                IDX_PULSE_FREQ: next_st.pulse_freq = hwdata[23:0];
                IDX_POWER_BIAS: next_st.power_bias = hwdata[23:0];
                IDX_EVENT_FLAGS: clr_vec = hwdata[23:0];
                IDX_EVENT_MASK: next_st.mask = hwdata[23:0] & FLAGS_IMPL;
                IDX_IRQ_CONFIG: next_st.irq_cfg = hwdata[1:0];
                IDX_CYCLE_LEN: next_st.cycle_len = hwdata[23:0];
                default: next_st.cycle_len = st.cycle_len;
            endcase
        end

        // sequential divide and square root after each cycle
        case (st.calc)
            CALC_DIV_POWER, CALC_DIV_ISQ, CALC_DIV_VSQ: begin
                dq = div_step(st.div_quo, st.div_rem,
                    cycle_length(st.cycle_len));
                next_st.div_rem = dq[73:49];
                next_st.div_quo = dq[48:0];
                next_st.step = st.step + 6'h01;
                quo = dq[48:0];
                if (st.step == 6'h30) begin
                    next_st.step = 6'h00;
                    next_st.root = 24'h000000;
                    next_st.root_rem = 26'h0000000;
                    next_st.div_rem = 25'h0000000;
                    next_st.root_ovf = (quo[48:24] != 25'h0000000);
                    next_st.radicand = {quo[23:0], 24'h000000};
                    if (st.calc == CALC_DIV_POWER) begin
                        // signed mean, saturated at the fraction range
                        if (st.neg && quo > 49'h800000) begin
                            next_st.mean_power = 24'h800000;
                            set_vec[BIT_ENERGY_OVF] = 1'b1;
                        end else if (st.neg) begin
                            next_st.mean_power = (~quo[23:0]) + 24'h000001;
                        end else if (quo > 49'h7FFFFF) begin
                            next_st.mean_power = 24'h7FFFFF;
                            set_vec[BIT_ENERGY_OVF] = 1'b1;
                        end else begin
                            next_st.mean_power = quo[23:0];
                        end
                        next_st.div_quo = st.lat_isq;
                        next_st.calc = CALC_DIV_ISQ;
                    end else if (st.calc == CALC_DIV_ISQ) begin
                        next_st.calc = CALC_ROOT_I;
                    end else begin
                        next_st.calc = CALC_ROOT_V;
                    end
                end
            end
            CALC_ROOT_I, CALC_ROOT_V: begin
                rq = root_step(st.root_rem, st.root, st.radicand[47:46]);
                next_st.root_rem = rq[49:24];
                next_st.root = rq[23:0];
                next_st.radicand = {st.radicand[45:0], 2'b00};
                next_st.step = st.step + 6'h01;
                if (st.step == 6'h17) begin
                    next_st.step = 6'h00;
                    if (st.calc == CALC_ROOT_I) begin
                        next_st.rms_current = st.root_ovf ? 24'hFFFFFF
                            : rq[23:0];
                        set_vec[BIT_CURRENT_MS_OVF] = st.root_ovf;
                        next_st.div_quo = st.lat_vsq;
                        next_st.calc = CALC_DIV_VSQ;
                    end else begin
                        next_st.rms_voltage = st.root_ovf ? 24'hFFFFFF
                            : rq[23:0];
                        set_vec[BIT_VOLTAGE_MS_OVF] = st.root_ovf;
                        set_vec[BIT_CYCLE_COMPLETE] = 1'b1;
                        next_st.calc = CALC_IDLE;
                    end
                end
            end
            default: next_st.calc = CALC_IDLE;
        endcase

        // new conversion from the front end
        prod = $signed(sample_in.current) * $signed(sample_in.voltage);
        // only minus one times minus one leaves the fraction range
        pw = (prod[47:46] == 2'b01) ? 24'h7FFFFF : prod[46:23];
        acc_p = st.acc_power + {{25{pw[23]}}, pw}
            + {{25{st.power_bias[23]}}, st.power_bias};
        acc_i = st.acc_isq + {24'h000000, square_scaled(sample_in.current)};
        acc_v = st.acc_vsq + {24'h000000, square_scaled(sample_in.voltage)};
        if (sample_in.valid) begin
            next_st.inst_current = sample_in.current;
            next_st.inst_voltage = sample_in.voltage;
            next_st.inst_power = pw;
            set_vec[BIT_SAMPLE_READY] = 1'b1;
            set_vec[BIT_CURRENT_OVF] = sample_in.current_over;
            set_vec[BIT_VOLTAGE_OVF] = sample_in.voltage_over;
            if (st.conv_count + 24'h000001 >= cycle_length(st.cycle_len)) begin
                // end of computation cycle restarts the calculation
                next_st.conv_count = 24'h000000;
                next_st.neg = acc_p[48];
                next_st.div_quo = acc_p[48] ? (~acc_p) + 49'h1 : acc_p;
                next_st.div_rem = 25'h0000000;
                next_st.lat_isq = acc_i;
                next_st.lat_vsq = acc_v;
                next_st.acc_power = '0;
                next_st.acc_isq = '0;
                next_st.acc_vsq = '0;
                next_st.step = 6'h00;
                next_st.calc = CALC_DIV_POWER;
            end else begin
                next_st.conv_count = st.conv_count + 24'h000001;
                next_st.acc_power = acc_p;
                next_st.acc_isq = acc_i;
                next_st.acc_vsq = acc_v;
            end
        end

        // event flags: a set in the same cycle wins over a clear; for the command valid bit the clear wins
        set_vec[BIT_CYCLE_COMPLETE] = set_vec[BIT_CYCLE_COMPLETE]
            | event_in.calibration_done;
        set_vec[BIT_TEMP_UPDATED] = event_in.temperature_updated;
        set_vec[BIT_TEMP_OSC] = event_in.temperature_osc;
        set_vec[BIT_VOLTAGE_OSC] = event_in.voltage_osc;
        set_vec[BIT_CURRENT_OSC] = event_in.current_osc;
        set_vec[BIT_LOW_SUPPLY] = st.sup_sync[1];
        set_vec[BIT_SAG] = event_in.sag_detected;
        clr_vec[BIT_CMD_VALID] = 1'b0;
        if (!st.sup_sync[0]) begin
            clr_vec[BIT_LOW_SUPPLY] = 1'b0;
        end
        next_st.flags = ((st.flags & ~clr_vec) | set_vec) & FLAGS_IMPL;
        if (event_in.invalid_command || event_in.status_read_failed) begin
            next_st.flags[BIT_CMD_VALID] = 1'b0;
        end else if (addr_ok && !hwrite && idx == IDX_EVENT_FLAGS) begin
            next_st.flags[BIT_CMD_VALID] = 1'b1;
        end

        // energy pulse generator: phase accumulator in 1/32 hertz
        rate = {6'h00, st.pulse_freq};
        if (rate != 30'h0 && rate < PULSE_RATE_MIN) begin
            rate = PULSE_RATE_MIN;
        end
        if (rate > PULSE_RATE_MAX) begin
            rate = PULSE_RATE_MAX;
        end
        psum = st.pulse_acc + rate;
        fire = (psum >= PULSE_ACC_LIMIT);
        next_st.pulse_acc = fire ? psum - PULSE_ACC_LIMIT : psum;
        next_st.pulse_a_n = !(fire && !st.mean_power[23]);
        next_st.pulse_b_n = !(fire && st.mean_power[23]);

        // interrupt pin
        req = |(st.flags & st.mask);
        next_st.req_d = req;
        if (req && !st.req_d) begin
            next_st.irq_cnt = IRQ_PULSE_CYCLES;
        end else if (st.irq_cnt != 3'h0) begin
            next_st.irq_cnt = st.irq_cnt - 3'h1;
        end
        if (st.irq_cfg[BIT_IRQ_STYLE]) begin
            // pulse style; a request held high gives one pulse only
            next_st.irq_pin = (next_st.irq_cnt != 3'h0)
                ? st.irq_cfg[BIT_IRQ_POLARITY]
                : !st.irq_cfg[BIT_IRQ_POLARITY];
        end else begin
            next_st.irq_pin = req ? st.irq_cfg[BIT_IRQ_POLARITY]
                : !st.irq_cfg[BIT_IRQ_POLARITY];
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.pulse_freq <= PULSE_FREQ_RESET;
            st.power_bias <= POWER_BIAS_RESET;
            st.flags <= FLAGS_RESET;
            st.mask <= MASK_RESET;
            st.cycle_len <= CYCLE_LEN_RESET;
            st.irq_cfg <= IRQ_CONFIG_RESET;
            st.calc <= CALC_IDLE;
            st.pulse_a_n <= 1'b1;
            st.pulse_b_n <= 1'b1;
            st.irq_pin <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign energy_pulse_out_a_n = st.pulse_a_n;
    assign energy_pulse_out_b_n = st.pulse_b_n;
    assign irq_out = st.irq_pin;

endmodule // meter_result_and_event_registers

`default_nettype wire

// ==== meter_regs_checker.sv ====
// concurrent checks on the ports of the meter register bank
`timescale 1ns/10ps
`default_nettype none
module meter_regs_checker (
    // clock, reset and bus
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // front end and pulse pins
    input wire meter_regs_pkg::sample_in_s sample_in,
    input wire meter_regs_pkg::event_in_s event_in,
    input wire logic energy_pulse_out_a_n,
    input wire logic energy_pulse_out_b_n
);
    import meter_regs_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // read address phase taken for one register index
    // ------------------------------------------------------------------
    sequence s_rd(logic [7:0] idx);
        hsel && htrans[1] && hready && !hwrite && haddr == {22'h0, idx, 2'h0};
    endsequence
    a_upper_zero: assert property (hrdata[31:24] == 8'h00)
        else $error("read data upper byte not zero");
    a_flags_reserved: assert property (s_rd(IDX_EVENT_FLAGS) |=>
        (hrdata[23:0] & ~FLAGS_IMPL) == 24'h0) else $error("flag spare set");
    a_mask_reserved: assert property (s_rd(IDX_EVENT_MASK) |=>
        (hrdata[23:0] & ~FLAGS_IMPL) == 24'h0) else $error("mask spare set");
    // a clamped rate still leaves eight cycles per pulse
    a_pulse_gap: assert property ($fell(energy_pulse_out_a_n) |=>
        energy_pulse_out_a_n [*7]) else $error("pulses closer than 8");
    a_pulse_one_side: assert property (
        energy_pulse_out_a_n || energy_pulse_out_b_n)
        else $error("both pulse outputs active");
    a_inst_current: assert property (sample_in.valid ##1
        s_rd(IDX_INST_CURRENT) |=> hrdata[23:0] == $past(sample_in.current, 2))
        else $error("current sample not latched");
    a_sample_flag: assert property (sample_in.valid ##1
        s_rd(IDX_EVENT_FLAGS) |=> hrdata[BIT_SAMPLE_READY])
        else $error("sample ready flag missing");
    a_sag_flag: assert property (event_in.sag_detected ##1
        s_rd(IDX_EVENT_FLAGS) |=> hrdata[BIT_SAG]) else $error("sag flag missing");
    a_cmd_invalid: assert property (event_in.invalid_command ##1
        s_rd(IDX_EVENT_FLAGS) |=> !hrdata[BIT_CMD_VALID])
        else $error("command valid flag not dropped");
endmodule // meter_regs_checker
bind meter_result_and_event_registers meter_regs_checker meter_regs_checker_i (
    .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .sample_in, .event_in, .energy_pulse_out_a_n, .energy_pulse_out_b_n);
`default_nettype wire

// ==== meter_host_model.sv ====
// ahb-lite master standing in for the host processor
`timescale 1ns/10ps
`default_nettype none
module meter_host_model (
    // clock and answer
    input wire logic core_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // request
    output var logic hsel = 1'b0,
    output var logic [31:0] haddr = 32'h0,
    output var logic [1:0] htrans = 2'h0,
    output var logic hwrite = 1'b0,
    output var logic [2:0] hsize = 3'h2,
    output var logic [31:0] hwdata = 32'h0
);
    // no wait count assumed: only the bench timeout ends a stalled wait
    task automatic xfer(input logic wr, input logic [7:0] idx,
            input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask
endmodule // meter_host_model
`default_nettype wire

// ==== meter_result_and_event_registers_tb.sv ====
// self-checking bench for the meter register bank
`timescale 1ns/10ps
`default_nettype none
module meter_result_and_event_registers_tb;
    import meter_regs_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel, hwrite, hready, hresp, irq_out, ea_n, eb_n;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    sample_in_s smp = '0;
    event_in_s evt = '0;
    supply_pins_s sup = '0;
    int fail_count = 0, checks_done = 0, cyc = 0, pulses = 0, pulses_b = 0;
    int p0;
    meter_host_model meter_host_model_i (.core_clk, .hready, .hrdata, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata);
    meter_result_and_event_registers meter_result_and_event_registers_i (
        .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout(hready), .hresp, .hrdata, .sample_in(smp),
        .event_in(evt), .supply_pins(sup), .energy_pulse_out_a_n(ea_n),
        .energy_pulse_out_b_n(eb_n), .irq_out);
    always #50 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        pulses <= pulses + int'(!ea_n);
        pulses_b <= pulses_b + int'(!eb_n);
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_is(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        meter_host_model_i.xfer(1'b0, idx, 32'h0, d);
        check(d, exp);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        meter_host_model_i.xfer(1'b1, idx, d, x);
    endtask
    task automatic strobe(input logic [1:0] ovf, input logic [7:0] ev);
        smp <= '{1'b1, 24'h400000, 24'hC00000, ovf[1], ovf[0]};
        evt <= event_in_s'(ev);
        @(posedge core_clk);
        smp.valid <= 1'b0;
        evt <= '0;
    endtask
    task automatic irq_is(input logic exp);
        repeat (3) @(posedge core_clk);
        check({31'h0, irq_out}, {31'h0, exp});
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        reg_is(IDX_PULSE_FREQ, 32'h000FA000);
        reg_is(IDX_POWER_BIAS, 32'h0);
        reg_is(IDX_EVENT_FLAGS, 32'h1);
        reg_is(IDX_EVENT_MASK, 32'h0);
        irq_is(1'b1);
        wr(IDX_EVENT_MASK, 32'hFFFFFFFF);
        reg_is(IDX_EVENT_MASK, 32'h009370DF);
        irq_is(1'b0);
        wr(IDX_EVENT_MASK, 32'h2);
        irq_is(1'b1);
        strobe(2'h0, 8'h00);
        reg_is(IDX_INST_CURRENT, 32'h00400000);
        reg_is(IDX_INST_VOLTAGE, 32'h00C00000);
        reg_is(IDX_INST_POWER, 32'h00E00000);
        strobe(2'h3, 8'hFF);
        reg_is(IDX_EVENT_FLAGS, 32'h009300DA);
        reg_is(IDX_EVENT_FLAGS, 32'h009300DB);
        irq_is(1'b0);
        wr(IDX_EVENT_FLAGS, 32'h2);
        reg_is(IDX_EVENT_FLAGS, 32'h009300D9);
        irq_is(1'b1);
        wr(IDX_EVENT_FLAGS, 32'h00FFFFFF);
        reg_is(IDX_EVENT_FLAGS, 32'h1);
        sup <= '{1'b1, 1'b0};
        repeat (4) @(posedge core_clk);
        sup <= '0;
        wr(IDX_EVENT_FLAGS, 32'h4);
        reg_is(IDX_EVENT_FLAGS, 32'h5);
        sup <= '{1'b0, 1'b1};
        repeat (4) @(posedge core_clk);
        wr(IDX_EVENT_FLAGS, 32'h4);
        reg_is(IDX_EVENT_FLAGS, 32'h1);
        // 32000 Hz at 10 MHz gives ten pulses in 3125 cycles
        p0 = pulses;
        repeat (3125) @(posedge core_clk);
        check({31'h0, (pulses - p0) inside {[9:11]}}, 32'h1);
        wr(IDX_CYCLE_LEN, 32'h1);
        strobe(2'h0, 8'h00);
        repeat (250) @(posedge core_clk);
        strobe(2'h0, 8'h00);
        repeat (250) @(posedge core_clk);
        reg_is(IDX_MEAN_POWER, 32'h00E00000);
        reg_is(IDX_RMS_CURRENT, 32'h00800000);
        reg_is(IDX_RMS_VOLTAGE, 32'h00800000);
        reg_is(IDX_EVENT_FLAGS, 32'h00900001);
        wr(IDX_POWER_BIAS, 32'h00800000);
        reg_is(IDX_POWER_BIAS, 32'h00800000);
        strobe(2'h0, 8'h00);
        repeat (250) @(posedge core_clk);
        reg_is(IDX_MEAN_POWER, 32'h00800000);
        // 625 cycles hold exactly two accumulator wraps
        p0 = pulses_b;
        repeat (625) @(posedge core_clk);
        check(32'(pulses_b - p0), 32'h2);
        wr(IDX_PULSE_FREQ, 32'h00000002);
        reg_is(IDX_PULSE_FREQ, 32'h00000002);
        wr(IDX_INST_POWER, 32'h0);
        reg_is(IDX_INST_POWER, 32'h00E00000);
        reg_is(8'h0D, 32'h0);
        wr(IDX_IRQ_CONFIG, 32'h1);
        irq_is(1'b0);
        give_verdict();
    end
endmodule // meter_result_and_event_registers_tb
`default_nettype wire
